// file: inc/acs_pkg.sv
package acs_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RES_W  = 12;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_MAXCONV     = 8'h04;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [3:0] OFS_CHSEL_PAGE  = 4'h1;
	localparam logic [1:0] OFS_RESULT_PAGE = 2'h1;

	// Control register fields
	localparam int unsigned CTRL_CASCADE_BIT = 0;
	localparam int unsigned CTRL_SIMUL_BIT   = 1;
	localparam int unsigned CTRL_SW_P_BIT    = 2;
	localparam int unsigned CTRL_SW_S_BIT    = 3;
	localparam int unsigned CTRL_RST_P_BIT   = 4;
	localparam int unsigned CTRL_RST_S_BIT   = 5;

	// Maximum conversion fields
	localparam int unsigned MAX_P_LSB = 0;
	localparam int unsigned MAX_S_LSB = 4;

	// Status fields
	localparam int unsigned ST_BUSY_BIT    = 0;
	localparam int unsigned ST_OWNER_BIT   = 1;
	localparam int unsigned ST_PEND_P_BIT  = 2;
	localparam int unsigned ST_PEND_S_BIT  = 3;
	localparam int unsigned ST_STATE_P_LSB = 4;
	localparam int unsigned ST_STATE_S_LSB = 8;

	// Reset values
	localparam logic [15:0] CHSEL_RST = 16'h0000;
	localparam logic [3:0]  MAX_P_RST = 4'h0;
	localparam logic [2:0]  MAX_S_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} acs_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} acs_axil_rsp_t;

	typedef struct packed {
		logic       start;
		logic [2:0] mux_a;
		logic [2:0] mux_b;
		logic       sample_both;
		logic       convert_b;
	} acs_core_cmd_t;

	typedef struct packed {
		logic              done;
		logic [RES_W-1:0]  result;
	} acs_core_rsp_t;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a[1:0] == 2'h0) &&
			((a == OFS_CTRL) || (a == OFS_MAXCONV) || (a == OFS_STATUS) ||
			 (a[7:4] == OFS_CHSEL_PAGE) || (a[7:6] == OFS_RESULT_PAGE));
	endfunction : addr_hit

endpackage : acs_pkg

// file: verilog/acs_axil_slave.sv
module acs_axil_slave (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire acs_pkg::acs_axil_req_t axil_req,
	output acs_pkg::acs_axil_rsp_t      axil_rsp,
	output logic                       wr_en,
	output logic [7:0]                 wr_addr,
	output logic [31:0]                wr_data,
	output logic [3:0]                 wr_strb,
	output logic [7:0]                 rd_addr,
	input  wire logic [31:0]           rd_data
);

	typedef struct packed {
		logic                   aw_ok;
		logic [7:0]             awaddr;
		logic                   w_ok;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   ar_ok;
		logic [7:0]             araddr;
		acs_pkg::acs_axil_rsp_t rsp;
	} acs_slv_state_t;

	acs_slv_state_t q;
	acs_slv_state_t d;

	always_comb begin
		d = q;
		wr_en = 1'h0;
		if (axil_req.awvalid && q.rsp.awready) begin
			d.aw_ok  = 1'h1;
			d.awaddr = axil_req.awaddr;
		end
		if (axil_req.wvalid && q.rsp.wready) begin
			d.w_ok  = 1'h1;
			d.wdata = axil_req.wdata;
			d.wstrb = axil_req.wstrb;
		end
		if (q.rsp.bvalid && axil_req.bready)
			d.rsp.bvalid = 1'h0;
		// Address and data may arrive in either order; commit once both are held
		if (q.aw_ok && q.w_ok && !q.rsp.bvalid) begin
			wr_en        = 1'h1;
			d.aw_ok      = 1'h0;
			d.w_ok       = 1'h0;
			d.rsp.bvalid = 1'h1;
			d.rsp.bresp  = acs_pkg::addr_hit(q.awaddr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
		end
		d.rsp.awready = !d.aw_ok && !d.rsp.bvalid;
		d.rsp.wready  = !d.w_ok && !d.rsp.bvalid;
		if (axil_req.arvalid && q.rsp.arready) begin
			d.ar_ok  = 1'h1;
			d.araddr = axil_req.araddr;
		end
		if (q.rsp.rvalid && axil_req.rready)
			d.rsp.rvalid = 1'h0;
		if (q.ar_ok) begin
			d.ar_ok      = 1'h0;
			d.rsp.rvalid = 1'h1;
			d.rsp.rdata  = acs_pkg::addr_hit(q.araddr) ? rd_data : 32'h0000_0000;
			d.rsp.rresp  = acs_pkg::addr_hit(q.araddr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
		end
		d.rsp.arready = !d.ar_ok && !d.rsp.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign axil_rsp = q.rsp;
	assign wr_addr  = q.awaddr;
	assign wr_data  = q.wdata;
	assign wr_strb  = q.wstrb;
	assign rd_addr  = q.araddr;

endmodule : acs_axil_slave

// file: verilog/acs_sequencer.sv
module acs_sequencer (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire acs_pkg::acs_axil_req_t axil_req,
	output acs_pkg::acs_axil_rsp_t      axil_rsp,
	input  wire logic                   pwm_trigger_a,
	input  wire logic                   pwm_trigger_b,
	input  wire logic                   ext_trigger,
	input  wire acs_pkg::acs_core_rsp_t core_rsp,
	output acs_pkg::acs_core_cmd_t      core_cmd,
	output logic [1:0]                  sequence_end,
	output logic                        seq_busy
);

	typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_WAIT} acs_phase_t;

	typedef struct packed {
		logic                                 cascade;
		logic                                 simul;
		logic [3:0]                           max_p;
		logic [2:0]                           max_s;
		logic [3:0][15:0]                     chsel;
		logic [15:0][acs_pkg::RES_W-1:0]      results;
		acs_phase_t                           phase;
		logic                                 owner_sec;
		logic [3:0]                           state_p;
		logic [2:0]                           state_s;
		logic [3:0]                           res_p;
		logic [2:0]                           res_s;
		logic                                 second_b;
		logic                                 pend_p;
		logic                                 pend_s;
		logic                                 ext_s1;
		logic                                 ext_s2;
		logic                                 ext_prev;
		acs_pkg::acs_core_cmd_t               cmd;
		logic [1:0]                           seq_end;
		logic                                 busy;
	} acs_seq_state_t;

	acs_seq_state_t q;
	acs_seq_state_t d;

	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;

	logic        ctrl_wr;
	logic        sw_p;
	logic        sw_s;
	logic        rst_p;
	logic        rst_s;
	logic        ext_rise;
	logic        trig_p;
	logic        trig_s;
	logic        grant_p;
	logic        grant_s;
	logic [3:0]  cur_idx;
	logic [3:0]  fld_now;
	logic [3:0]  slot_now;
	logic        at_last;

	acs_axil_slave u_slave (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.axil_req (axil_req),
		.axil_rsp (axil_rsp),
		.wr_en    (wr_en),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.wr_strb  (wr_strb),
		.rd_addr  (rd_addr),
		.rd_data  (rd_data)
	);

	// Pick field idx out of the four packed select registers
	function automatic logic [3:0] field_of(input logic [3:0][15:0] sel, input logic [3:0] idx);
		logic [15:0] w;
		w = sel[idx[3:2]];
		field_of = w[{idx[1:0], 2'h0} +: 4];
	endfunction : field_of

	assign ctrl_wr = wr_en && (wr_addr == acs_pkg::OFS_CTRL) && wr_strb[0];
	assign sw_p    = ctrl_wr && wr_data[acs_pkg::CTRL_SW_P_BIT];
	assign sw_s    = ctrl_wr && wr_data[acs_pkg::CTRL_SW_S_BIT];
	assign rst_p   = ctrl_wr && wr_data[acs_pkg::CTRL_RST_P_BIT];
	assign rst_s   = ctrl_wr && wr_data[acs_pkg::CTRL_RST_S_BIT];

	// Only the second synchroniser stage feeds the edge detector
	assign ext_rise = q.ext_s2 && !q.ext_prev;

	assign trig_p = pwm_trigger_a || sw_p || ext_rise || (q.cascade && (pwm_trigger_b || sw_s));
	assign trig_s = !q.cascade && (pwm_trigger_b || sw_s);

	// Secondary fields sit at 8..15; primary folds to 0..7 unless cascaded
	assign cur_idx  = q.owner_sec ? {1'h1, q.state_s} :
		(q.cascade ? q.state_p : {1'h0, q.state_p[2:0]});
	assign slot_now = q.owner_sec ? {1'h1, q.res_s} :
		(q.cascade ? q.res_p : {1'h0, q.res_p[2:0]});
	assign at_last  = q.owner_sec ? (q.state_s == q.max_s) :
		(q.cascade ? (q.state_p == q.max_p) : (q.state_p[2:0] == q.max_p[2:0]));
	assign fld_now  = field_of(q.chsel, cur_idx);

	always_comb begin
		d = q;
		grant_p = 1'h0;
		grant_s = 1'h0;
		d.cmd.start = 1'h0;
		d.seq_end = 2'h0;
		d.ext_s1 = ext_trigger;
		d.ext_s2 = q.ext_s1;
		d.ext_prev = q.ext_s2;

		if (wr_en) begin
			if (ctrl_wr) begin
				d.cascade = wr_data[acs_pkg::CTRL_CASCADE_BIT];
				d.simul   = wr_data[acs_pkg::CTRL_SIMUL_BIT];
			end
			if ((wr_addr == acs_pkg::OFS_MAXCONV) && wr_strb[0]) begin
				d.max_p = wr_data[acs_pkg::MAX_P_LSB +: 4];
				d.max_s = wr_data[acs_pkg::MAX_S_LSB +: 3];
			end
			if ((wr_addr[7:4] == acs_pkg::OFS_CHSEL_PAGE) && (wr_addr[1:0] == 2'h0)) begin
				if (wr_strb[0])
					d.chsel[wr_addr[3:2]][7:0] = wr_data[7:0];
				if (wr_strb[1])
					d.chsel[wr_addr[3:2]][15:8] = wr_data[15:8];
			end
		end

		case (q.phase)
			PH_IDLE: begin
				if (q.pend_p) begin
					grant_p = 1'h1;
					d.owner_sec = 1'h0;
					d.second_b = 1'h0;
					d.phase = PH_ISSUE;
				end else if (q.pend_s && !q.cascade) begin
					grant_s = 1'h1;
					d.owner_sec = 1'h1;
					d.second_b = 1'h0;
					d.phase = PH_ISSUE;
				end
			end
			PH_ISSUE: begin
				d.cmd.start = 1'h1;
				d.cmd.mux_a = fld_now[2:0];
				d.cmd.mux_b = fld_now[2:0];
				if (q.simul) begin
					d.cmd.sample_both = 1'h1;
					d.cmd.convert_b = q.second_b;
				end else begin
					d.cmd.sample_both = 1'h0;
					d.cmd.convert_b = fld_now[3];
				end
				d.phase = PH_WAIT;
			end
			PH_WAIT: begin
				if (core_rsp.done) begin
					d.results[slot_now] = core_rsp.result;
					// Pointer steps once per result, so a pair moves it by two
					if (q.owner_sec)
						d.res_s = q.res_s + 3'h1;
					else
						d.res_p = q.res_p + 4'h1;
					if (q.simul && !q.second_b) begin
						d.second_b = 1'h1;
						d.phase = PH_ISSUE;
					end else begin
						d.second_b = 1'h0;
						if (at_last) begin
							d.seq_end = q.owner_sec ? 2'h2 : 2'h1;
							if (q.owner_sec) begin
								d.state_s = 3'h0;
								d.res_s = 3'h0;
							end else begin
								d.state_p = 4'h0;
								d.res_p = 4'h0;
							end
							d.phase = PH_IDLE;
						end else begin
							if (q.owner_sec)
								d.state_s = q.state_s + 3'h1;
							else
								d.state_p = q.state_p + 4'h1;
							d.phase = PH_ISSUE;
						end
					end
				end
			end
			default: d.phase = PH_IDLE;
		endcase

		// Software rewind also aborts a running sequence of that sequencer
		if (rst_p) begin
			d.state_p = 4'h0;
			d.res_p = 4'h0;
			if (!q.owner_sec && (q.phase != PH_IDLE))
				d.phase = PH_IDLE;
		end
		if (rst_s) begin
			d.state_s = 3'h0;
			d.res_s = 3'h0;
			if (q.owner_sec && (q.phase != PH_IDLE))
				d.phase = PH_IDLE;
		end

		// A new trigger beats a grant or rewind in the same cycle
		d.pend_p = (q.pend_p && !grant_p && !rst_p) || trig_p;
		d.pend_s = ((q.pend_s && !grant_s && !rst_s) || trig_s) && !q.cascade;
		d.busy = (d.phase != PH_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.chsel <= {4{acs_pkg::CHSEL_RST}};
			q.max_p <= acs_pkg::MAX_P_RST;
			q.max_s <= acs_pkg::MAX_S_RST;
		end else begin
			q <= d;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_addr == acs_pkg::OFS_CTRL) begin
			rd_data[acs_pkg::CTRL_CASCADE_BIT] = q.cascade;
			rd_data[acs_pkg::CTRL_SIMUL_BIT]   = q.simul;
		end else if (rd_addr == acs_pkg::OFS_MAXCONV) begin
			rd_data[acs_pkg::MAX_P_LSB +: 4] = q.max_p;
			rd_data[acs_pkg::MAX_S_LSB +: 3] = q.max_s;
		end else if (rd_addr == acs_pkg::OFS_STATUS) begin
			rd_data[acs_pkg::ST_BUSY_BIT]         = q.busy;
			rd_data[acs_pkg::ST_OWNER_BIT]        = q.owner_sec;
			rd_data[acs_pkg::ST_PEND_P_BIT]       = q.pend_p;
			rd_data[acs_pkg::ST_PEND_S_BIT]       = q.pend_s;
			rd_data[acs_pkg::ST_STATE_P_LSB +: 4] = q.state_p;
			rd_data[acs_pkg::ST_STATE_S_LSB +: 3] = q.state_s;
		end else if (rd_addr[7:4] == acs_pkg::OFS_CHSEL_PAGE) begin
			rd_data[15:0] = q.chsel[rd_addr[3:2]];
		end else if (rd_addr[7:6] == acs_pkg::OFS_RESULT_PAGE) begin
			rd_data[acs_pkg::RES_W-1:0] = q.results[rd_addr[5:2]];
		end
	end

	assign core_cmd     = q.cmd;
	assign sequence_end = q.seq_end;
	assign seq_busy     = q.busy;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_a_done;
		(q.phase == PH_WAIT) && core_rsp.done && q.simul && !q.second_b;
	endsequence

	sequence s_b_issue;
		q.second_b && (q.phase == PH_ISSUE) ##1 (q.cmd.start && q.cmd.convert_b && q.cmd.sample_both);
	endsequence

	property p_cascade_primary;
		$rose(q.busy) && q.cascade |-> !q.owner_sec;
	endproperty

	property p_secondary_slots;
		(q.phase == PH_WAIT) && core_rsp.done && q.owner_sec |-> slot_now[3];
	endproperty

	property p_auto_continue;
		(q.phase == PH_WAIT) && core_rsp.done && !at_last && !rst_p && !rst_s
			|-> ##2 q.cmd.start;
	endproperty

	property p_result_write;
		(q.phase == PH_WAIT) && core_rsp.done
			|=> q.results[$past(slot_now)] == $past(core_rsp.result);
	endproperty

	property p_pending_held;
		q.busy && !q.owner_sec && trig_s && !rst_s |=> q.pend_s && !q.owner_sec;
	endproperty

	property p_priority;
		(q.phase == PH_IDLE) && q.pend_p && q.pend_s && !q.cascade && !rst_s
			|=> (q.phase == PH_ISSUE) && !q.owner_sec && q.pend_s;
	endproperty

	property p_seq_decode;
		(q.phase == PH_ISSUE) && !q.simul
			|=> q.cmd.start && !q.cmd.sample_both && (q.cmd.convert_b == $past(fld_now[3]))
				&& (q.cmd.mux_a == $past(fld_now[2:0]));
	endproperty

	property p_simul_pair;
		(q.phase == PH_ISSUE) && q.simul
			|=> q.cmd.sample_both && (q.cmd.mux_a == q.cmd.mux_b) && (q.cmd.mux_a == $past(fld_now[2:0]));
	endproperty

	property p_pair_order;
		s_a_done and (!rst_p && !rst_s) |=> s_b_issue;
	endproperty

	property p_pair_stride;
		s_a_done and (!q.owner_sec && !rst_p) |=> q.res_p == $past(q.res_p) + 4'h1;
	endproperty

	property p_trig_route;
		pwm_trigger_b && q.cascade |=> q.pend_p && !q.pend_s;
	endproperty

	property p_end_rewind;
		q.seq_end[0] |-> (q.state_p == 4'h0) && (q.res_p == 4'h0) && (q.phase == PH_IDLE);
	endproperty

	property p_field_store;
		wr_en && (wr_addr[7:4] == acs_pkg::OFS_CHSEL_PAGE) && (wr_addr[1:0] == 2'h0) && (wr_strb[1:0] == 2'h3)
			|=> q.chsel[$past(wr_addr[3:2])] == $past(wr_data[15:0]);
	endproperty

	chk_cascade_primary_only: assert property (p_cascade_primary)
		else $error("secondary sequencer ran while cascaded");
	chk_secondary_slot_range: assert property (p_secondary_slots)
		else $error("secondary result outside slots 8 to 15");
	chk_auto_next_conv: assert property (p_auto_continue)
		else $error("next conversion not issued two cycles after result");
	chk_result_slot_write: assert property (p_result_write)
		else $error("result not stored at current slot");
	chk_pending_held: assert property (p_pending_held)
		else $error("secondary request lost while primary busy");
	chk_primary_priority: assert property (p_priority)
		else $error("primary not granted first");
	chk_seq_decode: assert property (p_seq_decode)
		else $error("sequential field decode wrong");
	chk_simul_decode: assert property (p_simul_pair)
		else $error("simultaneous pair select wrong");
	chk_pair_order: assert property (p_pair_order)
		else $error("hold B not converted right after hold A");
	chk_pair_stride: assert property (p_pair_stride)
		else $error("result pointer did not step after hold A result");
	chk_trig_cascade: assert property (p_trig_route)
		else $error("pwm trigger B not routed to cascaded sequencer");
	chk_end_rewind: assert property (p_end_rewind)
		else $error("primary pointers not rewound at sequence end");
	chk_field_store: assert property (p_field_store)
		else $error("channel select register not stored");

endmodule : acs_sequencer

// file: verif/acs_core_model.sv
module acs_core_model (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [2:0]             lat,
	input  wire acs_pkg::acs_core_cmd_t core_cmd,
	output acs_pkg::acs_core_rsp_t      core_rsp
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0]  cnt_q;
	logic [3:0]  wait_q;
	logic        busy_q;
	logic [11:0] val_q;

	// Result tags conversion order and decode, so a wrong slot or mux shows up
	always @(posedge aclk) begin
		core_rsp.done <= 1'b0;
		// Idle result line flips every cycle; stale data must never look valid
		core_rsp.result <= ~core_rsp.result;
		if (!aresetn) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			core_rsp.result <= 12'h0;
		end else if (core_cmd.start) begin
			val_q <= {cnt_q, core_cmd.sample_both, core_cmd.convert_b, core_cmd.mux_b, core_cmd.mux_a};
			cnt_q <= cnt_q + 4'h1;
			wait_q <= {1'b0, lat};
			busy_q <= 1'b1;
		end else if (busy_q && wait_q == 4'h0) begin
			core_rsp.done <= 1'b1;
			core_rsp.result <= val_q;
			busy_q <= 1'b0;
		end else if (busy_q) begin
			wait_q <= wait_q - 4'h1;
		end
	end
endmodule : acs_core_model

// file: verif/tb_adc_autoconversion_sequencer.sv
module tb_adc_autoconversion_sequencer;
	timeunit 1ns;
	timeprecision 1ns;

	logic                   aclk = 1'b0;
	logic                   aresetn = 1'b0;
	acs_pkg::acs_axil_req_t req = '0;
	acs_pkg::acs_axil_rsp_t rsp;
	logic                   trig_a = 1'b0;
	logic                   trig_b = 1'b0;
	logic                   ext = 1'b0;
	logic [2:0]             lat = 3'h0;
	acs_pkg::acs_core_cmd_t cmd;
	acs_pkg::acs_core_rsp_t crsp;
	logic [1:0]             seq_end;
	logic                   busy;
	logic [31:0]            seed = 32'h8BA6;
	logic [3:0]             fld [16];
	logic [11:0]            exp_res [16];
	bit                     exp_ok [16];
	logic [1:0]             got_end [$];
	logic [1:0]             exp_end [$];
	int                     error_cnt = 0;
	int                     n_compared = 0;
	int                     conv_cnt = 0;
	int                     maxc [2];
	bit                     casc;
	bit                     simul;
	logic [31:0]            d;
	logic [1:0]             r;

	always #50 aclk = ~aclk;

	acs_sequencer dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .pwm_trigger_a(trig_a),
		.pwm_trigger_b(trig_b), .ext_trigger(ext), .core_rsp(crsp), .core_cmd(cmd), .sequence_end(seq_end),
		.seq_busy(busy));
	acs_core_model core (.aclk(aclk), .aresetn(aresetn), .lat(lat), .core_cmd(cmd), .core_rsp(crsp));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Core latency wanders every cycle so both prompt and slow answers occur
	always @(posedge aclk) begin
		lat <= 3'(xs());
		if (aresetn && seq_end != 2'h0)
			got_end.push_back(seq_end);
	end

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: value %h, expected %h", $time, g, e);
		end
	endtask : cmp32

	task automatic cmp_end(input logic [1:0] g, input logic [1:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: sequence end %b, expected %b", $time, g, e);
		end
	endtask : cmp_end

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		bit fin;
		fin = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				r = rsp.bresp;
				req.bready <= 1'b0;
				fin = 1'b1;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		bit fin;
		fin = 1'b0;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				d = rsp.rdata;
				r = rsp.rresp;
				req.rready <= 1'b0;
				fin = 1'b1;
			end
		end
	endtask : axi_rd

	task automatic pulse(input bit a, input bit b);
		@(posedge aclk);
		trig_a <= a;
		trig_b <= b;
		@(posedge aclk);
		trig_a <= 1'b0;
		trig_b <= 1'b0;
	endtask : pulse

	task automatic setup(input bit c, input bit s, input int m0, input int m1);
		casc = c;
		simul = s;
		maxc[0] = m0;
		maxc[1] = m1;
		for (int i = 0; i < 16; i++)
			fld[i] = 4'(xs());
		axi_wr(acs_pkg::OFS_CTRL, {30'h0, s, c});
		axi_wr(acs_pkg::OFS_MAXCONV, {25'h0, 3'(m1), 4'(m0)});
		for (int i = 0; i < 4; i++)
			axi_wr(8'h10 + 8'(4 * i), {16'h0, fld[4 * i + 3], fld[4 * i + 2], fld[4 * i + 1], fld[4 * i]});
	endtask : setup

	// Reference: one accepted start yields every programmed state in order
	task automatic predict(input int s);
		int   base;
		int   p;
		logic cb;
		base = (s == 1) ? 8 : 0;
		p = 0;
		for (int i = 0; i <= maxc[s]; i++) begin
			for (int h = 0; h <= int'(simul); h++) begin
				cb = simul ? h[0] : fld[base + i][3];
				exp_res[base + p] = {4'(conv_cnt), simul, cb, fld[base + i][2:0], fld[base + i][2:0]};
				exp_ok[base + p] = 1'b1;
				conv_cnt++;
				p = (p + 1) % (casc ? 16 : 8);
			end
		end
		exp_end.push_back(s == 1 ? 2'h2 : 2'h1);
	endtask : predict

	task automatic check_run(input int k);
		bit sb;
		sb = 1'b0;
		for (int t = 0; t < 5000 && got_end.size() < exp_end.size(); t++) begin
			@(posedge aclk);
			sb |= busy;
		end
		repeat (4) @(posedge aclk);
		cmp32(32'(got_end.size()), 32'(exp_end.size()));
		cmp32({31'h0, sb}, 32'h1);
		cmp32({31'h0, busy}, 32'h0);
		while (exp_end.size() > 0 && got_end.size() > 0)
			cmp_end(got_end.pop_front(), exp_end.pop_front());
		exp_end.delete();
		got_end.delete();
		for (int i = 0; i < 16; i++) begin
			if (exp_ok[i]) begin
				axi_rd(8'h40 + 8'(4 * i));
				cmp32(d, {20'h0, exp_res[i]});
			end
		end
		axi_rd(acs_pkg::OFS_STATUS);
		cmp32(d & 32'h7FD, 32'h0);
		$display("test %0d done", k);
	endtask : check_run

	initial begin
		repeat (60000) @(posedge aclk);
		cmp32(32'h0, 32'h1);
		summarize();
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(acs_pkg::OFS_CTRL);
		cmp32(d, 32'h0);
		axi_rd(acs_pkg::OFS_MAXCONV);
		cmp32(d, 32'h0);
		for (int i = 0; i < 4; i++) begin
			axi_rd(8'h10 + 8'(4 * i));
			cmp32(d, 32'h0);
		end
		axi_rd(8'h0C);
		cmp32({d[29:0], r}, {30'h0, acs_pkg::RESP_SLVERR});
		axi_wr(acs_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		cmp32({30'h0, r}, 32'h0);
		axi_rd(acs_pkg::OFS_STATUS);
		cmp32(d, 32'h0);
		$display("test registers done");
		// Full-length sequences in all four mode combinations, both triggers at once
		for (int m = 0; m < 4; m++) begin
			setup(m[1], m[0], m[1] ? (m[0] ? 7 : 15) : (m[0] ? 3 : 7), m[0] ? 3 : 7);
			pulse(1'b1, 1'b1);
			predict(0);
			if (!casc)
				predict(1);
			check_run(m);
		end
		setup(1'b0, 1'b0, int'(xs() % 8), 7);
		pulse(1'b1, 1'b0);
		predict(0);
		check_run(4);
		pulse(1'b0, 1'b1);
		predict(1);
		check_run(5);
		axi_wr(acs_pkg::OFS_CTRL, 32'h8);
		@(posedge aclk);
		ext <= 1'b1;
		repeat (3) @(posedge aclk);
		ext <= 1'b0;
		predict(1);
		predict(0);
		check_run(6);
		// Primary request queued behind the secondary, then rewound away
		axi_wr(acs_pkg::OFS_CTRL, 32'h8);
		pulse(1'b1, 1'b0);
		axi_wr(acs_pkg::OFS_CTRL, 32'h10);
		predict(1);
		check_run(7);
		setup(1'b1, 1'b0, 15, 0);
		axi_wr(acs_pkg::OFS_CTRL, 32'h5);
		predict(0);
		check_run(8);
		pulse(1'b0, 1'b1);
		predict(0);
		check_run(9);
		summarize();
	end
endmodule : tb_adc_autoconversion_sequencer
